// >>> verilog/gpc_pkg.sv
// Package for the general-purpose pin port: register map, field layout, reset values.
// Assumes a host register port that presents 6-bit addresses and 16-bit words.
package gpc_pkg;
    localparam int          NUM_PINS       = 7;
    localparam int          ADDR_W         = 6;
    localparam int          DATA_W         = 16;
    localparam logic [5:0]  ADDR_DIR       = 6'h0b;
    localparam logic [5:0]  ADDR_DOUT      = 6'h0c;
    // Direction register fields
    localparam int          DIR_DRV_LSB    = 14;
    localparam int          DIR_OEN_LSB    = 7;
    localparam int          DIR_IEN_LSB    = 0;
    // Data-out register fields
    localparam int          DOUT_DRV_LSB   = 14;
    localparam int          DOUT_SDO_LSB   = 12;
    localparam int          DOUT_CLKO_LSB  = 10;
    localparam int          DOUT_IRQ_LSB   = 8;
    localparam int          DOUT_PUP_BIT   = 7;
    localparam int          DOUT_VAL_LSB   = 0;
    // Reset values: weakest drives, all pins inputs, pull-up on
    localparam logic [15:0] DIR_RESET      = 16'h007f;
    localparam logic [15:0] DOUT_RESET     = 16'h0080;
    // Alternate status pins
    localparam int          ALT_BUSY_PIN   = 0;
    localparam int          ALT_RESULT_PIN = 1;

    typedef struct packed {
        logic [1:0] low_group_drive_strength;
        logic [1:0] high_group_drive_strength;
        logic [1:0] serial_out_drive;
        logic [1:0] clock_out_drive;
        logic [1:0] irq_drive;
        logic       irq_pullup_enable;
    } gpc_pad_ctl_t;

    typedef struct packed {
        logic [NUM_PINS-1:0] out_val;
        logic [NUM_PINS-1:0] out_en_n;
    } gpc_pin_drive_t;
endpackage : gpc_pkg

// >>> verilog/gpc_pin_sync.sv
// Two-flop synchroniser for the pin input levels.
// Assumes pins are asynchronous to clk_sys_in.
`timescale 1ns/1ps
module gpc_pin_sync (
    input  wire logic                     clk_sys_in,
    input  wire logic                     reset_n_in,
    input  wire logic [gpc_pkg::NUM_PINS-1:0] async_in,
    output logic      [gpc_pkg::NUM_PINS-1:0] sync_out
);
    logic [gpc_pkg::NUM_PINS-1:0] meta_r;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : gpc_pin_sync

// >>> verilog/gpc_pad_control.sv
// Pin port control: two 16-bit registers on the host register port, pad drivers,
// drive-strength and pull-up controls, and the alternate status mapping.
// Assumes a single-cycle register port on clk_sys_in; pad wires resolved outside.
//
// Notes on behaviour
// - Each of the seven pins has its own output-request and input-request bit.
// - Direction register bits 13..7 request output for pins 7..1.
// - Direction register bits 6..0 request input for pins 7..1.
// - A pin with both requests set is an input and its driver stays off, except pins 1 and 2 while alternate status is on.
// - During reset all pins float, and they come out of reset as inputs.
// - Data-out bits 6..0 give the driven level of pins 7..1 when output.
// - Direction bits 15..14 set drive of pins 1-4, reset 00 weakest.
// - Data-out bits 15..14 set drive of pins 5-7, reset 00 weakest.
// - Data-out bits 13..12, 11..10, 9..8 set serial-out, clock-out, irq drives.
// - Data-out bit 7 enables the irq pull-up, set by default.
// - With alternate status on, pin 1 shows out-of-idle and pin 2 result valid.
`timescale 1ns/1ps
module gpc_pad_control (
    input  wire logic                                 clk_sys_in,
    input  wire logic                                 reset_n_in,
    // Host register port
    input  wire logic                                 reg_wr_in,
    input  wire logic [gpc_pkg::ADDR_W-1:0]           reg_addr_in,
    input  wire logic [gpc_pkg::DATA_W-1:0]           reg_wdata_in,
    output logic      [gpc_pkg::DATA_W-1:0]           reg_rdata_out,
    // Alternate status from the transceiver core
    input  wire logic                                 alt_status_en_in,
    input  wire logic                                 core_busy_in,
    input  wire logic                                 result_valid_in,
    // Pads
    input  wire logic [gpc_pkg::NUM_PINS-1:0]         pin_in,
    output logic      [gpc_pkg::NUM_PINS-1:0]         pin_out,
    output logic      [gpc_pkg::NUM_PINS-1:0]         pin_oe_n_out,
    output logic      [gpc_pkg::NUM_PINS-1:0]         pin_data_out,
    output gpc_pkg::gpc_pad_ctl_t                     pad_ctl_out
);
    logic [gpc_pkg::DATA_W-1:0]   dir_r;
    logic [gpc_pkg::DATA_W-1:0]   dout_r;
    logic [gpc_pkg::NUM_PINS-1:0] pin_sync;
    logic [gpc_pkg::NUM_PINS-1:0] out_req;
    logic [gpc_pkg::NUM_PINS-1:0] in_req;
    logic [gpc_pkg::NUM_PINS-1:0] out_val;
    logic [gpc_pkg::NUM_PINS-1:0] drive_en;
    logic [gpc_pkg::NUM_PINS-1:0] alt_mask;
    logic [gpc_pkg::NUM_PINS-1:0] alt_val;
    logic                         wr_dir;
    logic                         wr_dout;
    gpc_pkg::gpc_pin_drive_t      drv_nxt;
    gpc_pkg::gpc_pin_drive_t      drv_r;

    assign wr_dir  = reg_wr_in && (reg_addr_in == gpc_pkg::ADDR_DIR);
    assign wr_dout = reg_wr_in && (reg_addr_in == gpc_pkg::ADDR_DOUT);

    // Reset values make every pin an input with drivers off
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dir_r  <= gpc_pkg::DIR_RESET;
            dout_r <= gpc_pkg::DOUT_RESET;
        end else begin
            if (wr_dir) begin
                dir_r <= reg_wdata_in;
            end
            if (wr_dout) begin
                dout_r <= reg_wdata_in;
            end
        end
    end

    // Field extraction
    assign out_req = dir_r[gpc_pkg::DIR_OEN_LSB +: gpc_pkg::NUM_PINS];
    assign in_req  = dir_r[gpc_pkg::DIR_IEN_LSB +: gpc_pkg::NUM_PINS];
    assign out_val = dout_r[gpc_pkg::DOUT_VAL_LSB +: gpc_pkg::NUM_PINS];

    // Alternate status takes pins 1 and 2 regardless of direction bits
    always_comb begin
        alt_mask = '0;
        alt_val  = '0;
        alt_mask[gpc_pkg::ALT_BUSY_PIN]   = alt_status_en_in;
        alt_mask[gpc_pkg::ALT_RESULT_PIN] = alt_status_en_in;
        alt_val[gpc_pkg::ALT_BUSY_PIN]    = core_busy_in;
        alt_val[gpc_pkg::ALT_RESULT_PIN]  = result_valid_in;
    end

    // Input request wins over output request
    assign drive_en = (out_req & ~in_req) | alt_mask;

    assign drv_nxt.out_val  = (alt_mask & alt_val) | (~alt_mask & out_val & drive_en);
    assign drv_nxt.out_en_n = ~drive_en;

    // Registered pad drive; floats while reset is held
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            drv_r.out_val  <= '0;
            drv_r.out_en_n <= '1;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    assign pin_out      = drv_r.out_val;
    assign pin_oe_n_out = drv_r.out_en_n;

    gpc_pin_sync u_sync (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .async_in   (pin_in),
        .sync_out   (pin_sync)
    );

    // Pins not enabled as inputs read as zero to the core
    assign pin_data_out = pin_sync & in_req;

    assign pad_ctl_out.low_group_drive_strength  = dir_r[gpc_pkg::DIR_DRV_LSB +: 2];
    assign pad_ctl_out.high_group_drive_strength = dout_r[gpc_pkg::DOUT_DRV_LSB +: 2];
    assign pad_ctl_out.serial_out_drive          = dout_r[gpc_pkg::DOUT_SDO_LSB +: 2];
    assign pad_ctl_out.clock_out_drive           = dout_r[gpc_pkg::DOUT_CLKO_LSB +: 2];
    assign pad_ctl_out.irq_drive                 = dout_r[gpc_pkg::DOUT_IRQ_LSB +: 2];
    assign pad_ctl_out.irq_pullup_enable         = dout_r[gpc_pkg::DOUT_PUP_BIT];

    // Read mux is side-effect free; other addresses belong elsewhere and read zero
    assign reg_rdata_out = (reg_addr_in == gpc_pkg::ADDR_DIR)  ? dir_r  :
                           (reg_addr_in == gpc_pkg::ADDR_DOUT) ? dout_r : '0;
endmodule : gpc_pad_control

// >>> test/gpc_pin_model.sv
// Outside circuitry on the seven pins: resolves each pad wire.
// Assumes a weak pull-down on every pin; the pad driver wins when enabled.
`timescale 1ns/1ps
module gpc_pin_model (
    input  wire logic [6:0] pad_value_in,
    input  wire logic [6:0] pad_oe_n_in,
    input  wire logic [6:0] ext_val_in,
    input  wire logic       ext_en_in,
    output logic      [6:0] level_out
);
    // Released pins take ext_val_in while ext_en_in is set, else fall to the pull-down, never to the last value
    assign level_out = (~pad_oe_n_in & pad_value_in) | (pad_oe_n_in & (ext_en_in ? ext_val_in : 7'h00));
endmodule : gpc_pin_model

// >>> test/gpc_pad_control_props.sv
// Checker for the pin port, watching only the top module's ports.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
module gpc_props (
    input wire logic clk_sys_in, reset_n_in, reg_wr_in, alt_status_en_in, core_busy_in,
    input wire logic result_valid_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in, reg_rdata_out,
    input wire logic [6:0] pin_in, pin_out, pin_oe_n_out, pin_data_out,
    input wire gpc_pkg::gpc_pad_ctl_t pad_ctl_out
);
    logic dir_rd, dout_rd, dir_wr;
    assign dir_rd  = reg_addr_in == 6'h0b;
    assign dout_rd = reg_addr_in == 6'h0c;
    assign dir_wr  = reg_wr_in && dir_rd;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    a_reset_float: assert property ($rose(reset_n_in) |-> pin_oe_n_out == 7'h7f)
        else $error("pins driven just after reset");
    // Pins 1 and 2 left out: the alternate status may own them
    a_dir_drive: assert property (dir_rd && $stable(reg_rdata_out) && $stable(reg_addr_in) |-> pin_oe_n_out[6:2] == ~(reg_rdata_out[13:9] & ~reg_rdata_out[6:2]))
        else $error("driver enables disagree with direction");
    a_out_level: assert property (dout_rd && $stable(reg_rdata_out) && $stable(reg_addr_in) |-> ((pin_out ^ reg_rdata_out[6:0]) & ~pin_oe_n_out & 7'h7c) == 7'h00)
        else $error("driven level disagrees with data-out");
    a_pad_high: assert property (dout_rd |-> pad_ctl_out[8:0] == reg_rdata_out[15:7])
        else $error("pad controls disagree with data-out");
    a_pad_low: assert property (dir_rd |-> pad_ctl_out[10:9] == reg_rdata_out[15:14])
        else $error("low group drive disagrees");
    a_input_mask: assert property ((dir_rd && $stable(pin_in) && !reg_wr_in)[*3] |-> pin_data_out == (pin_in & reg_rdata_out[6:0]))
        else $error("input levels wrong");
    a_alt_pins: assert property (alt_status_en_in && $past(alt_status_en_in) && $past(reset_n_in) && $stable(core_busy_in) && $stable(result_valid_in) |-> pin_oe_n_out[1:0] == 2'b00 && pin_out[1:0] == {result_valid_in, core_busy_in})
        else $error("status pins wrong");
    a_unmapped_zero: assert property (!dir_rd && !dout_rd |-> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_read_back: assert property (dir_wr |=> !dir_rd || reg_rdata_out == $past(reg_wdata_in))
        else $error("direction read-back wrong");
endmodule : gpc_props
bind gpc_pad_control gpc_props u_props (.clk_sys_in, .reset_n_in, .reg_wr_in, .alt_status_en_in,
    .core_busy_in, .result_valid_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .pin_in,
    .pin_out, .pin_oe_n_out, .pin_data_out, .pad_ctl_out);

// >>> test/testbench.sv
// Self-checking bench for the pin port, with the pin model on the pads.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic clk_sys_in = 0, reset_n_in = 0, reg_wr_in = 0, alt_status_en_in = 0, ext_en = 0;
    logic core_busy_in = 0, result_valid_in = 0;
    logic [5:0] reg_addr_in = 6'h00;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out;
    logic [6:0] pin_in, pin_out, pin_oe_n_out, pin_data_out, ext_val = 7'h00;
    gpc_pkg::gpc_pad_ctl_t pad_ctl_out;
    int fails = 0, check_count = 0;
    gpc_pad_control u_dut (.clk_sys_in, .reset_n_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
        .reg_rdata_out, .alt_status_en_in, .core_busy_in, .result_valid_in, .pin_in, .pin_out,
        .pin_oe_n_out, .pin_data_out, .pad_ctl_out);
    gpc_pin_model u_pins (.pad_value_in(pin_out), .pad_oe_n_in(pin_oe_n_out), .ext_val_in(ext_val),
        .ext_en_in(ext_en), .level_out(pin_in));
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    task step(input int n); repeat (n) @(posedge clk_sys_in); #1; endtask : step
    task wr(input logic [5:0] a, input logic [15:0] d);
        step(1); reg_wr_in = 1; reg_addr_in = a; reg_wdata_in = d;
        step(1); reg_wr_in = 0;
    endtask : wr
    task rd(input logic [5:0] a, input logic [15:0] e); reg_addr_in = a; #1; `CHK(reg_rdata_out, e) endtask : rd
    task t_reset;
        rd(6'h0b, 16'h007f);
        rd(6'h0c, 16'h0080);
        rd(6'h0d, 16'h0000);
        `CHK(pin_oe_n_out, 7'h7f)
        `CHK(pad_ctl_out, 11'h001)
    endtask : t_reset
    task t_drive;
        wr(6'h0b, 16'hff80); wr(6'h0c, 16'hff55); step(1);
        `CHK(pin_oe_n_out, 7'h00)
        `CHK(pin_out, 7'h55)
        `CHK(pad_ctl_out, 11'h7fe)
        rd(6'h0c, 16'hff55);
        wr(6'h0c, 16'h002a); step(1);
        `CHK(pin_out, 7'h2a)
        `CHK(pad_ctl_out, 11'h600)
    endtask : t_drive
    task t_input;
        wr(6'h0b, 16'h3fff); step(1); ext_en = 1; ext_val = 7'h2a; step(3);
        `CHK(pin_oe_n_out, 7'h7f)
        `CHK(pin_data_out, 7'h2a)
        wr(6'h0b, 16'h000f); step(3);
        `CHK(pin_data_out, 7'h0a)
        ext_en = 0;
    endtask : t_input
    task t_alt;
        wr(6'h0b, 16'h0000); alt_status_en_in = 1; core_busy_in = 1; step(2);
        `CHK(pin_oe_n_out, 7'h7c)
        `CHK(pin_out[1:0], 2'b01)
        core_busy_in = 0; result_valid_in = 1; step(2);
        `CHK(pin_out[1:0], 2'b10)
        alt_status_en_in = 0;
    endtask : t_alt
    task conclude;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        step(3); reset_n_in = 1;
        t_reset; t_drive; t_input; t_alt;
        reset_n_in = 0; #1;
        `CHK(pin_oe_n_out, 7'h7f)
        step(1); reset_n_in = 1;
        t_reset;
        conclude;
    end
    // About 30 cycles expected
    initial begin #20000; fails++; conclude; end
endmodule : testbench
